// ==== rtl/fcw_pkg.sv ====
// Shared constants and types for the fieldbus command word decoder.
//
// Functional notes
// R1: Profile code 0 converts, code 5 passes.
// R2: Converting profile translates; pass-through leaves word untouched.
// R3: Bit 0 high readies; low ramps to stop.
// R4: Bit 1 low coasts, then blocks power-on.
// R5: Bit 2 low quick-stops in configured time.
// R6: Bit 3 high runs if permitted; low inhibits.
// R7: Fieldbus permissive source takes permit from bit 3.
// R8: Bit 4 low forces ramp output zero.
// R9: Bit 5 low freezes ramp; high enables acceleration.
// R10: Bit 6 low zeroes ramp input, if sourced.
// R11: Bit 7 rising clears fault, blocks power-on.
// R12: Bit 10 low, nonzero data: keep last.
// R13: Bit 10 low, all zero: release, lock ramp.
// R14: Bit 11 picks location b, if sourced.
// R15: Bits 12 to 15 are user control bits.
// R16: Master sends 16-bit packed command word.
// R17: Bits 8 and 9 are ignored.
// R18: Coast beats quick stop beats ramp stop.
package fcw_pkg;

   // Command word shape and bit positions.
   localparam int          CMD_W       = 16;
   localparam int          REF_W       = 16;
   localparam int          BIT_RSTOP   = 0;
   localparam int          BIT_COAST   = 1;
   localparam int          BIT_QUICK   = 2;
   localparam int          BIT_RUN     = 3;
   localparam int          BIT_ROUT    = 4;
   localparam int          BIT_HOLD    = 5;
   localparam int          BIT_RIN     = 6;
   localparam int          BIT_FRESET  = 7;
   localparam int          BIT_REMOTE  = 10;
   localparam int          BIT_LOC     = 11;
   localparam int          USER_LSB    = 12;
   localparam int          USER_W      = 4;
   localparam logic [15:0] RSVD_MASK   = 16'h0300;

   // Profile selection codes.
   localparam int          PROF_W      = 8;
   localparam logic [7:0]  PROF_CONV   = 8'h00;
   localparam logic [7:0]  PROF_PASS   = 8'h05;

   // Native internal command word bit positions.
   localparam int          NAT_STOP    = 0;
   localparam int          NAT_START   = 1;
   localparam int          NAT_FRESET  = 4;
   localparam int          NAT_LOC     = 5;
   localparam int          NAT_RUNDIS  = 6;
   localparam int          NAT_ROUT0   = 11;
   localparam int          NAT_HOLD    = 12;
   localparam int          NAT_RIN0    = 13;

   // Reset values.
   localparam logic [15:0] CMD_RST     = 16'h0000;
   localparam logic [15:0] REF_RST     = 16'h0000;
   localparam logic [15:0] QS_CNT_RST  = 16'h0000;
   localparam int          QS_W        = 16;

   // Drive sequencing states.
   typedef enum logic [2:0] {
      ST_POWER_ON_BLOCKED,
      ST_ARMED,
      ST_READY_TO_RUN,
      ST_RUNNING_ENABLED,
      ST_RUNNING_BLOCKED,
      ST_FIRST_STOP_ACTIVE,
      ST_SECOND_STOP_ACTIVE,
      ST_THIRD_STOP_ACTIVE
   } fcw_state_t;

endpackage

// ==== rtl/fcw_ctl_if.sv ====
// Internal carrier between the decoder top and its ramp and timer helpers.
`timescale 1ns/1ps
interface fcw_ctl_if;
   logic [15:0] cmd_word;       // Active command word.
   logic        ramp_lock;      // Ramp locked after control release.
   logic        rin_src_fb;     // Ramp input zero is sourced from the fieldbus.
   logic        ramp_out_zero;  // Ramp output forced to zero.
   logic        ramp_hold;      // Ramp output frozen.
   logic        ramp_in_zero;   // Ramp input forced to zero.
   logic        accel_en;       // Accelerator enabled.
   logic        qs_start;       // Quick stop timer runs while high.
   logic [15:0] qs_limit;       // Quick stop time in clock cycles.
   logic        qs_expired;     // Quick stop time has run out.

   modport top  (output cmd_word, ramp_lock, rin_src_fb, qs_start, qs_limit,
                 input  ramp_out_zero, ramp_hold, ramp_in_zero, accel_en, qs_expired);
   modport ramp (input  cmd_word, ramp_lock, rin_src_fb,
                 output ramp_out_zero, ramp_hold, ramp_in_zero, accel_en);
   modport tmr  (input  qs_start, qs_limit,
                 output qs_expired);
endinterface

// ==== rtl/fcw_ramp_ctl.sv ====
// Ramp generator control decode from the active command word.
`timescale 1ns/1ps
module fcw_ramp_ctl (
   // Clock and reset.
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   // Decoder side.
   fcw_ctl_if.ramp   ctl
);

   logic rout_zero_reg, rout_zero_next;  // Ramp output zero.
   logic hold_reg,      hold_next;       // Ramp output hold.
   logic rin_zero_reg,  rin_zero_next;   // Ramp input zero.
   logic accel_reg,     accel_next;      // Accelerator enabled.

   // Decode; a locked ramp after control release also holds the output.
   always_comb begin
      rout_zero_next = ~ctl.cmd_word[fcw_pkg::BIT_ROUT];                   // R8
      hold_next      = ~ctl.cmd_word[fcw_pkg::BIT_HOLD] | ctl.ramp_lock;   // R9
      accel_next     = ctl.cmd_word[fcw_pkg::BIT_HOLD] & ~ctl.ramp_lock;   // R9
      rin_zero_next  = ctl.rin_src_fb & ~ctl.cmd_word[fcw_pkg::BIT_RIN];   // R10
   end

   // Reset leaves the ramp forced to zero and frozen, the safe state.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         rout_zero_reg <= 1'b1;
         hold_reg      <= 1'b1;
         rin_zero_reg  <= 1'b0;
         accel_reg     <= 1'b0;
      end else begin
         rout_zero_reg <= rout_zero_next;
         hold_reg      <= hold_next;
         rin_zero_reg  <= rin_zero_next;
         accel_reg     <= accel_next;
      end
   end

   assign ctl.ramp_out_zero = rout_zero_reg;
   assign ctl.ramp_hold     = hold_reg;
   assign ctl.ramp_in_zero  = rin_zero_reg;
   assign ctl.accel_en      = accel_reg;

endmodule

// ==== rtl/fcw_qstop_timer.sv ====
// Quick stop deadline timer.
`timescale 1ns/1ps
module fcw_qstop_timer (
   // Clock and reset.
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   // Decoder side.
   fcw_ctl_if.tmr    ctl
);

   logic [15:0] cnt_reg, cnt_next;   // Cycles spent in quick stop.
   logic        exp_reg, exp_next;   // Deadline reached.

   // Count while the stop lasts, saturate at the limit, clear otherwise.
   always_comb begin
      cnt_next = fcw_pkg::QS_CNT_RST;
      exp_next = 1'b0;
      if (ctl.qs_start) begin
         cnt_next = (cnt_reg >= ctl.qs_limit) ? cnt_reg : cnt_reg + 16'h0001;
         exp_next = (cnt_reg >= ctl.qs_limit);                              // R5
      end
   end

   // Registering only.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         cnt_reg <= fcw_pkg::QS_CNT_RST;
         exp_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         exp_reg <= exp_next;
      end
   end

   assign ctl.qs_expired = exp_reg;

endmodule

// ==== rtl/fcw_decoder.sv ====
// Fieldbus command word decoder and drive sequencer top.
`timescale 1ns/1ps
module fcw_decoder (
   // Clock and reset.
   input  wire logic               sys_clk_in,
   input  wire logic               rst_n_in,
   // Command word write from the fieldbus master.
   input  wire logic               cmd_wr_in,
   input  wire logic [15:0]        cmd_word_in,
   input  wire logic [15:0]        ref_in,
   // Configuration.
   input  wire logic [7:0]         profile_code_in,
   input  wire logic               run_perm_src_fb_in,
   input  wire logic               run_perm_ext_in,
   input  wire logic               ramp_in_src_fb_in,
   input  wire logic               fault_reset_src_fb_in,
   input  wire logic               loc_src_fb_in,
   input  wire logic [15:0]        quick_stop_time_in,
   // Drive status.
   input  wire logic               stop_done_in,
   input  wire logic               fault_active_in,
   // Native command and state.
   output logic                    profile_pass_out,
   output logic [15:0]             native_cmd_out,
   output logic [15:0]             native_ref_out,
   output fcw_pkg::fcw_state_t     drive_state_out,
   // Control ownership.
   output logic                    fb_control_out,
   output logic                    ref_lock_out,
   output logic                    ext_loc_b_out,
   // Stop and run controls.
   output logic                    ramp_stop_out,
   output logic                    coast_stop_out,
   output logic                    quick_stop_out,
   output logic                    run_permit_out,
   output logic                    fault_reset_out,
   // Ramp generator controls.
   output logic                    ramp_out_zero_out,
   output logic                    ramp_hold_out,
   output logic                    ramp_in_zero_out,
   output logic                    accel_en_out,
   // Application bits.
   output logic [3:0]              user_bits_out
);

   fcw_ctl_if ctl ();

   // Intake state.
   logic [7:0]  profile_reg, profile_next;    // Latched profile code.
   logic        pass_reg,    pass_next;       // Pass-through profile flag, kept in a flop.
   logic [15:0] word_reg,    word_next;       // Active command word.
   logic [15:0] ref_reg,     ref_next;        // Active reference.
   logic        fbctl_reg,   fbctl_next;      // Fieldbus owns control.
   logic        lock_reg,    lock_next;       // Reference and ramp locked.
   logic        freset_reg,  freset_next;     // Fault reset pulse.
   logic [15:0] masked_in;                    // Incoming word without reserved bits.

   // Sequencer state.
   fcw_pkg::fcw_state_t state_reg, state_next;
   logic        permit;                       // Run permissive in effect.
   logic        conv;                         // Converting profile active.

   // Output state.
   logic [15:0] native_reg,  native_next;     // Native command word.
   logic        loc_reg,     loc_next;        // Location b selected.
   logic        permit_reg;                   // Registered permissive.
   logic        rstop_reg,   rstop_next;      // Ramp stop in progress.
   logic        coast_reg,   coast_next;      // Coast stop in progress.
   logic        quick_reg,   quick_next;      // Quick stop in progress.
   logic [3:0]  user_reg,    user_next;       // User bits.

   assign conv      = (profile_reg == fcw_pkg::PROF_CONV);
   assign masked_in = cmd_word_in & ~fcw_pkg::RSVD_MASK;                    // R17

   // A permissive taken from the fieldbus follows bit 3 directly.
   assign permit = run_perm_src_fb_in ? word_reg[fcw_pkg::BIT_RUN]
                                      : run_perm_ext_in;                   // R7

   // Profile and word intake. An unknown profile code keeps the last valid
   // selection, so a glitch in configuration never drops the drive into an
   // undefined decode.
   always_comb begin
      profile_next = profile_reg;
      word_next    = word_reg;
      ref_next     = ref_reg;
      fbctl_next   = fbctl_reg;
      lock_next    = lock_reg;
      freset_next  = 1'b0;
      if (profile_code_in == fcw_pkg::PROF_CONV ||
          profile_code_in == fcw_pkg::PROF_PASS) begin
         profile_next = profile_code_in;                                   // R1
      end
      pass_next    = (profile_next == fcw_pkg::PROF_PASS);                 // R1
      if (cmd_wr_in) begin
         if (cmd_word_in[fcw_pkg::BIT_REMOTE]) begin
            // Remote bit set: the master owns control and the word is taken.
            word_next  = masked_in;
            ref_next   = ref_in;
            fbctl_next = 1'b1;
            lock_next  = 1'b0;
            freset_next = fault_reset_src_fb_in &
                          cmd_word_in[fcw_pkg::BIT_FRESET] &
                          ~word_reg[fcw_pkg::BIT_FRESET];                  // R11
         end else if (masked_in != fcw_pkg::CMD_RST || ref_in != fcw_pkg::REF_RST) begin
            // Nonzero data without the remote bit: keep the last word.
            word_next = word_reg;                                          // R12
            ref_next  = ref_reg;                                           // R12
         end else begin
            // All zero: hand control away and freeze reference and ramp.
            fbctl_next = 1'b0;                                             // R13
            lock_next  = 1'b1;                                             // R13
         end
      end
   end

   // Intake registers.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         profile_reg <= fcw_pkg::PROF_CONV;
         pass_reg    <= 1'b0;
         word_reg    <= fcw_pkg::CMD_RST;
         ref_reg     <= fcw_pkg::REF_RST;
         fbctl_reg   <= 1'b0;
         lock_reg    <= 1'b0;
         freset_reg  <= 1'b0;
      end else begin
         profile_reg <= profile_next;
         pass_reg    <= pass_next;
         word_reg    <= word_next;
         ref_reg     <= ref_next;
         fbctl_reg   <= fbctl_next;
         lock_reg    <= lock_next;
         freset_reg  <= freset_next;
      end
   end

   // Drive sequencer. Only the converting profile interprets the word; in
   // pass-through the drive's own logic decodes it, so this machine parks.
   // Stop priority is coast, then quick stop, then ramp stop.
   always_comb begin
      state_next = state_reg;
      if (!conv || fault_active_in || freset_reg) begin
         state_next = fcw_pkg::ST_POWER_ON_BLOCKED;                        // R11
      end else begin
         unique case (state_reg)
            fcw_pkg::ST_POWER_ON_BLOCKED: begin
               if (word_reg[fcw_pkg::BIT_COAST] && word_reg[fcw_pkg::BIT_QUICK] &&
                   !word_reg[fcw_pkg::BIT_RSTOP]) begin
                  state_next = fcw_pkg::ST_ARMED;
               end
            end
            fcw_pkg::ST_ARMED: begin
               if (!word_reg[fcw_pkg::BIT_COAST] || !word_reg[fcw_pkg::BIT_QUICK]) begin
                  state_next = fcw_pkg::ST_POWER_ON_BLOCKED;               // R4
               end else if (word_reg[fcw_pkg::BIT_RSTOP]) begin
                  state_next = fcw_pkg::ST_READY_TO_RUN;                   // R3
               end
            end
            fcw_pkg::ST_READY_TO_RUN,
            fcw_pkg::ST_RUNNING_BLOCKED: begin
               if (!word_reg[fcw_pkg::BIT_COAST] || !word_reg[fcw_pkg::BIT_QUICK]) begin
                  state_next = fcw_pkg::ST_POWER_ON_BLOCKED;               // R18
               end else if (!word_reg[fcw_pkg::BIT_RSTOP]) begin
                  state_next = fcw_pkg::ST_ARMED;                          // R3
               end else if (word_reg[fcw_pkg::BIT_RUN] && permit) begin
                  state_next = fcw_pkg::ST_RUNNING_ENABLED;                // R6
               end
            end
            fcw_pkg::ST_RUNNING_ENABLED: begin
               if (!word_reg[fcw_pkg::BIT_COAST]) begin
                  state_next = fcw_pkg::ST_SECOND_STOP_ACTIVE;             // R4
               end else if (!word_reg[fcw_pkg::BIT_QUICK]) begin
                  state_next = fcw_pkg::ST_THIRD_STOP_ACTIVE;              // R5
               end else if (!word_reg[fcw_pkg::BIT_RSTOP]) begin
                  state_next = fcw_pkg::ST_FIRST_STOP_ACTIVE;              // R3
               end else if (!word_reg[fcw_pkg::BIT_RUN] || !permit) begin
                  state_next = fcw_pkg::ST_RUNNING_BLOCKED;                // R6
               end
            end
            fcw_pkg::ST_FIRST_STOP_ACTIVE: begin
               // A harder stop asked for mid-ramp overrides the ramp stop.
               if (!word_reg[fcw_pkg::BIT_COAST]) begin
                  state_next = fcw_pkg::ST_SECOND_STOP_ACTIVE;             // R18
               end else if (!word_reg[fcw_pkg::BIT_QUICK]) begin
                  state_next = fcw_pkg::ST_THIRD_STOP_ACTIVE;              // R18
               end else if (stop_done_in) begin
                  state_next = fcw_pkg::ST_ARMED;                          // R3
               end
            end
            fcw_pkg::ST_SECOND_STOP_ACTIVE: begin
               if (stop_done_in) begin
                  state_next = fcw_pkg::ST_POWER_ON_BLOCKED;               // R4
               end
            end
            fcw_pkg::ST_THIRD_STOP_ACTIVE: begin
               // The deadline ends the stop even if standstill is not reported.
               if (!word_reg[fcw_pkg::BIT_COAST]) begin
                  state_next = fcw_pkg::ST_SECOND_STOP_ACTIVE;             // R18
               end else if (stop_done_in || ctl.qs_expired) begin
                  state_next = fcw_pkg::ST_POWER_ON_BLOCKED;               // R5
               end
            end
         endcase
      end
   end

   // Sequencer register.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         state_reg <= fcw_pkg::ST_POWER_ON_BLOCKED;
      end else begin
         state_reg <= state_next;
      end
   end

   // Output decode. Pass-through hands the stored word on untouched.
   always_comb begin
      rstop_next  = (state_reg == fcw_pkg::ST_FIRST_STOP_ACTIVE);
      coast_next  = (state_reg == fcw_pkg::ST_SECOND_STOP_ACTIVE);
      quick_next  = (state_reg == fcw_pkg::ST_THIRD_STOP_ACTIVE);
      user_next   = word_reg[fcw_pkg::USER_LSB +: fcw_pkg::USER_W];        // R15
      loc_next    = loc_src_fb_in ? word_reg[fcw_pkg::BIT_LOC] : loc_reg;  // R14
      native_next = fcw_pkg::CMD_RST;
      if (conv) begin
         native_next[fcw_pkg::NAT_STOP]   = rstop_next | coast_next | quick_next;
         native_next[fcw_pkg::NAT_START]  = (state_reg == fcw_pkg::ST_RUNNING_ENABLED);
         native_next[fcw_pkg::NAT_FRESET] = freset_reg;
         native_next[fcw_pkg::NAT_LOC]    = loc_next;
         native_next[fcw_pkg::NAT_RUNDIS] = ~permit;
         native_next[fcw_pkg::NAT_ROUT0]  = ctl.ramp_out_zero;
         native_next[fcw_pkg::NAT_HOLD]   = ctl.ramp_hold;
         native_next[fcw_pkg::NAT_RIN0]   = ctl.ramp_in_zero;             // R2
      end else begin
         native_next = word_reg;                                           // R2
      end
   end

   // Output registers.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         native_reg <= fcw_pkg::CMD_RST;
         loc_reg    <= 1'b0;
         permit_reg <= 1'b0;
         rstop_reg  <= 1'b0;
         coast_reg  <= 1'b0;
         quick_reg  <= 1'b0;
         user_reg   <= 4'h0;
      end else begin
         native_reg <= native_next;
         loc_reg    <= loc_next;
         permit_reg <= permit;
         rstop_reg  <= rstop_next;
         coast_reg  <= coast_next;
         quick_reg  <= quick_next;
         user_reg   <= user_next;
      end
   end

   // Helper connections.
   assign ctl.cmd_word   = word_reg;
   assign ctl.ramp_lock  = lock_reg;
   assign ctl.rin_src_fb = ramp_in_src_fb_in;
   assign ctl.qs_start   = (state_reg == fcw_pkg::ST_THIRD_STOP_ACTIVE);
   assign ctl.qs_limit   = quick_stop_time_in;

   fcw_ramp_ctl u_ramp (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .ctl        (ctl.ramp)
   );

   fcw_qstop_timer u_qstop (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .ctl        (ctl.tmr)
   );

   // Top outputs, all from flip-flops.
   assign profile_pass_out  = pass_reg;
   assign native_cmd_out    = native_reg;
   assign native_ref_out    = ref_reg;
   assign drive_state_out   = state_reg;
   assign fb_control_out    = fbctl_reg;
   assign ref_lock_out      = lock_reg;
   assign ext_loc_b_out     = loc_reg;
   assign ramp_stop_out     = rstop_reg;
   assign coast_stop_out    = coast_reg;
   assign quick_stop_out    = quick_reg;
   assign run_permit_out    = permit_reg;
   assign fault_reset_out   = freset_reg;
   assign ramp_out_zero_out = ctl.ramp_out_zero;
   assign ramp_hold_out     = ctl.ramp_hold;
   assign ramp_in_zero_out  = ctl.ramp_in_zero;
   assign accel_en_out      = ctl.accel_en;
   assign user_bits_out     = user_reg;

   // Checks on the decoder's own behaviour.
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   logic quiet;  // Converting profile and no fault event pending that would override the sequencer.
   assign quiet = conv && !fault_active_in && !freset_reg;

   profile_sel_a: assert property (profile_code_in == fcw_pkg::PROF_PASS // R1
      |=> ##1 profile_pass_out) else $error("pass-through profile not selected");
   pass_word_a: assert property (!conv && !$past(conv) |=> // R2
      native_cmd_out == $past(word_reg)) else $error("pass-through word altered");
   ramp_stop_a: assert property (quiet && state_reg == fcw_pkg::ST_RUNNING_ENABLED && // R3
      word_reg[1] && word_reg[2] && !word_reg[0] |=> state_reg == fcw_pkg::ST_FIRST_STOP_ACTIVE
      ##1 ramp_stop_out) else $error("ramp stop not entered");
   coast_prio_a: assert property (quiet && state_reg == fcw_pkg::ST_RUNNING_ENABLED && // R4
      !word_reg[1] |=> state_reg == fcw_pkg::ST_SECOND_STOP_ACTIVE)
      else $error("coast stop not taken first");
   quick_stop_a: assert property (quiet && state_reg == fcw_pkg::ST_RUNNING_ENABLED && // R5
      word_reg[1] && !word_reg[2] |=> state_reg == fcw_pkg::ST_THIRD_STOP_ACTIVE)
      else $error("quick stop not entered");
   run_enter_a: assert property (quiet && state_reg == fcw_pkg::ST_READY_TO_RUN && // R6
      word_reg[0] && word_reg[1] && word_reg[2] && word_reg[3] && run_perm_src_fb_in
      |=> state_reg == fcw_pkg::ST_RUNNING_ENABLED) else $error("run not enabled");
   fault_clr_a: assert property (cmd_wr_in && cmd_word_in[10] && cmd_word_in[7] && // R11
      !word_reg[7] && fault_reset_src_fb_in |=> fault_reset_out ##1 !fault_reset_out)
      else $error("fault reset pulse wrong");
   retain_word_a: assert property (cmd_wr_in && !cmd_word_in[10] && // R12
      (masked_in != 16'h0000 || ref_in != 16'h0000)
      |=> word_reg == $past(word_reg) && native_ref_out == $past(ref_reg))
      else $error("word not retained");
   release_ctl_a: assert property (cmd_wr_in && !cmd_word_in[10] && masked_in == 16'h0000 && // R13
      ref_in == 16'h0000 |=> !fb_control_out && ref_lock_out ##1 ramp_hold_out)
      else $error("control not released");
   user_bits_a: assert property (cmd_wr_in && cmd_word_in[10] |=> ##1 // R15
      user_bits_out == $past(cmd_word_in[15:12], 2)) else $error("user bits wrong");

   run_cov_c: cover property (state_reg == fcw_pkg::ST_READY_TO_RUN
      ##1 state_reg == fcw_pkg::ST_RUNNING_ENABLED);
   qstop_cov_c: cover property (state_reg == fcw_pkg::ST_THIRD_STOP_ACTIVE && ctl.qs_expired);
   release_cov_c: cover property ($fell(fb_control_out));

endmodule

// ==== verif/fcw_master_model.sv ====
// Fieldbus master model that writes command words.
`timescale 1ns/1ps
module fcw_master_model (
   // Clock.
   input  wire logic        sys_clk_in,
   // Command write.
   output logic             cmd_wr_out,
   output logic [15:0]      cmd_word_out,
   output logic [15:0]      ref_out
);
   // Idle until the first write.
   initial begin
      cmd_wr_out = 1'b0;
      cmd_word_out = 16'h0000;
      ref_out = 16'h0000;
   end
   // One word and its reference per pulse; idle lines show junk, not the old word.
   task automatic send(input logic [15:0] w, input logic [15:0] r);
      @(posedge sys_clk_in);
      cmd_wr_out <= 1'b1;
      cmd_word_out <= w;
      ref_out <= r;
      @(posedge sys_clk_in);
      cmd_wr_out <= 1'b0;
      cmd_word_out <= ~w;
      ref_out <= ~r;
   endtask
endmodule

// ==== verif/fcw_decoder_bench.sv ====
// Self-checking bench for the command word decoder.
`timescale 1ns/1ps
module fcw_decoder_bench;
   typedef struct {int k; logic [15:0] v;} fcw_note_t;
   fcw_note_t           q[$];    // Expected results, oldest first.
   fcw_note_t           n;       // Note being compared.
   logic                sys_clk_in = 1'b0;
   logic                rst_n_in = 1'b0;
   logic                wr;
   logic [15:0]         word, rf, r, ncmd, nref;
   logic [7:0]          prof = 8'h00;
   logic                done = 1'b0;
   logic                perm = 1'b0;
   logic [15:0]         qt = 16'h0004;  // Quick stop time, randomised after reset.
   logic [2:0]          st;
   logic [3:0]          ub;
   wire  logic [11:0]   fl;      // Stops, permit, ramp zeros, pass, owner, lock, loc b, reset, hold, accel.
   int                  fails = 0;
   int                  num_checks = 0;
   event                probe;
   always #12.5 sys_clk_in = ~sys_clk_in;
   fcw_decoder DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cmd_wr_in(wr),
      .cmd_word_in(word), .ref_in(rf), .profile_code_in(prof), .run_perm_src_fb_in(1'b1),
      .run_perm_ext_in(perm), .ramp_in_src_fb_in(1'b1), .fault_reset_src_fb_in(1'b1),
      .loc_src_fb_in(1'b1), .quick_stop_time_in(qt), .stop_done_in(done),
      .fault_active_in(1'b0), .profile_pass_out(fl[6]), .native_cmd_out(ncmd),
      .native_ref_out(nref), .drive_state_out(st), .fb_control_out(fl[5]),
      .ref_lock_out(fl[4]), .ext_loc_b_out(fl[3]), .ramp_stop_out(), .coast_stop_out(fl[11]),
      .quick_stop_out(fl[10]), .run_permit_out(fl[9]), .fault_reset_out(fl[2]),
      .ramp_out_zero_out(fl[8]), .ramp_hold_out(fl[1]), .ramp_in_zero_out(fl[7]),
      .accel_en_out(fl[0]), .user_bits_out(ub));
   fcw_master_model fm (.sys_clk_in(sys_clk_in), .cmd_wr_out(wr),
      .cmd_word_out(word), .ref_out(rf));
   // Prints the verdict; an unmatched note left over counts as a miss.
   task automatic close_out();
      if (fails == 0 && num_checks > 0 && q.size() == 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic compare_word(input logic [15:0] e, input logic [15:0] a);
      num_checks++;
      if (a !== e) begin
         fails++;
         $display("unexpected at %0t: exp %h got %h", $time, e, a);
      end
   endtask
   task automatic compare_state(input logic [2:0] e, input logic [2:0] a);
      num_checks++;
      if (a !== e) begin
         fails++;
         $display("unexpected state at %0t: exp %h got %h", $time, e, a);
      end
   endtask
   // Waits n edges, then notes a result and wakes the watcher at the settled half.
   task automatic chk(input int c, input int k, input logic [15:0] v);
      repeat (c) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      q.push_back('{k, v});
      ->probe;
   endtask
   task automatic cst(input int c, input fcw_pkg::fcw_state_t s);
      chk(c, 0, {13'h0000, s});
   endtask
   // Arms from any stopped state and runs; the permissive comes from bit 3.
   task automatic runup();
      @(posedge sys_clk_in);
      done <= 1'b0;
      fm.send(16'h5c7e, r);
      fm.send(16'h5c7f, r);
      cst(4, fcw_pkg::ST_RUNNING_ENABLED);
   endtask
   // Watcher: compares every pending note with the output of its kind.
   always @(probe) begin
      while (q.size() > 0) begin
         n = q.pop_front();
         case (n.k)
            0: compare_state(n.v[2:0], st);
            1: compare_word(n.v, ncmd);
            2: compare_word(n.v, nref);
            3: compare_word(n.v, {4'h0, fl});
            default: compare_word(n.v, {12'h000, ub});
         endcase
      end
   end
   initial begin
      r = 16'($urandom(32'h561219b5));
      repeat (12) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      perm <= 1'($urandom);
      qt <= 16'($urandom_range(6, 1));
      cst(1, fcw_pkg::ST_POWER_ON_BLOCKED);
      r = 16'($urandom) | 16'h0001;
      fm.send(16'h0406, r);
      cst(2, fcw_pkg::ST_ARMED);
      runup();
      chk(0, 1, 16'h0022);
      chk(0, 3, 16'h0229);
      chk(0, 4, 16'h0005);
      fm.send(16'h0000, ~r | 16'h0001);
      chk(3, 2, r);
      fm.send(16'h5f7f, r);
      chk(3, 1, 16'h0022);
      fm.send(16'h5c7b, r);
      cst(int'(qt) + 2, fcw_pkg::ST_THIRD_STOP_ACTIVE);
      chk(0, 3, 16'h0629);
      cst(1, fcw_pkg::ST_POWER_ON_BLOCKED);
      runup();
      fm.send(16'h5c7e, r);
      cst(3, fcw_pkg::ST_FIRST_STOP_ACTIVE);
      @(posedge sys_clk_in) done <= 1'b1;
      cst(3, fcw_pkg::ST_ARMED);
      runup();
      fm.send(16'h5cff, r);
      chk(0, 3, 16'h022d);
      cst(1, fcw_pkg::ST_POWER_ON_BLOCKED);
      runup();
      fm.send(16'h5c79, r);
      cst(3, fcw_pkg::ST_SECOND_STOP_ACTIVE);
      chk(0, 3, 16'h0a29);
      @(posedge sys_clk_in) done <= 1'b1;
      cst(3, fcw_pkg::ST_POWER_ON_BLOCKED);
      fm.send(16'h0000, 16'h0000);
      chk(3, 3, 16'h021a);
      @(posedge sys_clk_in) prof <= 8'h05;
      r = 16'($urandom) | 16'h0400;
      fm.send(r, ~r);
      chk(3, 1, r & ~fcw_pkg::RSVD_MASK);
      chk(0, 3, {6'h00, r[3], ~r[4], ~r[6], 3'b110, r[11], 1'b0, ~r[5], r[5]});
      @(negedge sys_clk_in);
      close_out();
   end
endmodule
